//--- logic/gswc_top.sv
/*
  gswc_top.sv: general-purpose pins, reset-time strap capture, wake output and apb registers.
  assumes: single clock pclk at 10 MHz; apb master follows the standard two-phase protocol;
  pin inputs are synchronous to pclk; the board drives the pads from the three pin signals.
*/
// Decided for this implementation: the APB interface to the registers and the register addresses.
// Function
// - eight pins, input-only or bidirectional per enable
// - pin 7 strap selects 16/8-bit eeprom
// - pins 6:5 give receive termination trim
// - pins 4:3 give transmit termination trim
// - pins 2:0 give equalization level, default 100
// - ring on channel 0 in L2 asserts wake
`timescale 1ns/10ps
`default_nettype none
`include "gswc_params.svh"
module gswc_top
  import gswc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] gpio_in,
  output logic [7:0] gpio_out,
  output logic [7:0] gpio_oe_n,
  input wire logic ring_ch0,
  input wire logic link_in_l2,
  output logic wake_out_n,
  output gswc_strap_s strap,
  output logic irq
);
  // ============================================================
  // apb decode
  function automatic logic is_reg(input logic [11:0] a, input logic [11:0] off);
    is_reg = (a == off);
  endfunction : is_reg

  logic wr_en;
  logic rd_en;
  logic mapped;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign mapped = is_reg(paddr, `GSWC_OFF_OE) || is_reg(paddr, `GSWC_OFF_DOUT) ||
    is_reg(paddr, `GSWC_OFF_DIN) || is_reg(paddr, `GSWC_OFF_STRAP) ||
    is_reg(paddr, `GSWC_OFF_IRQ_STAT) || is_reg(paddr, `GSWC_OFF_IRQ_EN) ||
    is_reg(paddr, `GSWC_OFF_IRQ_CLR) || is_reg(paddr, `GSWC_OFF_WAKE_CTRL);
  assign pslverr = psel && penable && !mapped;

  // ============================================================
  // strap capture sequencer
  gswc_state_e state;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= GSWC_ST_RESET;
    end else begin
      case (state)
        GSWC_ST_RESET: state <= GSWC_ST_SAMPLE;
        GSWC_ST_SAMPLE: state <= GSWC_ST_RUN;
        GSWC_ST_RUN: state <= GSWC_ST_RUN;
        default: state <= GSWC_ST_RESET;
      endcase
    end
  end

  // async reset loads defaults; pins are caught by a clocked edge after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap.eeprom_width_strap <= 1'b0;
      strap.rx_termination_trim <= `GSWC_RST_RX;
      strap.tx_termination_trim <= `GSWC_RST_TX;
      strap.driver_equalization_level <= `GSWC_RST_DEQ;
    end else if (state == GSWC_ST_SAMPLE) begin
      strap.eeprom_width_strap <= gpio_in[`GSWC_POS_EEW];
      strap.rx_termination_trim <= gpio_in[`GSWC_POS_RX_HI:`GSWC_POS_RX_LO];
      strap.tx_termination_trim <= gpio_in[`GSWC_POS_TX_HI:`GSWC_POS_TX_LO];
      strap.driver_equalization_level <= gpio_in[`GSWC_POS_DEQ_HI:`GSWC_POS_DEQ_LO];
    end
  end

  // ============================================================
  // pin direction and data
  logic [7:0] oe;
  logic [7:0] dout;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe <= `GSWC_RST_OE;
      dout <= `GSWC_RST_DOUT;
    end else if (wr_en) begin
      if (is_reg(paddr, `GSWC_OFF_OE)) begin
        oe <= pwdata[7:0];
      end
      if (is_reg(paddr, `GSWC_OFF_DOUT)) begin
        dout <= pwdata[7:0];
      end
    end
  end

  // pins stay released until straps are taken, so board resistors set them
  logic run;
  assign run = (state == GSWC_ST_RUN);
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      assign gpio_out[g] = dout[g];
      assign gpio_oe_n[g] = !(run && oe[g]);
    end
  endgenerate

  // ============================================================
  // wake output
  logic wake_en;
  logic wake_hold;
  logic wake_evt;
  assign wake_evt = run && wake_en && ring_ch0 && link_in_l2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_en <= 1'b1;
    end else if (wr_en && is_reg(paddr, `GSWC_OFF_WAKE_CTRL)) begin
      wake_en <= pwdata[0];
    end
  end
  // held until the link leaves L2, so a short ring pulse still wakes the host
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_hold <= 1'b0;
    end else if (wake_evt) begin
      wake_hold <= 1'b1;
    end else if (!link_in_l2) begin
      wake_hold <= 1'b0;
    end
  end
  assign wake_out_n = !wake_hold;

  // ============================================================
  // interrupts
  logic [7:0] din_q;
  logic [`GSWC_IRQ_W-1:0] irq_stat;
  logic [`GSWC_IRQ_W-1:0] irq_en;
  logic [`GSWC_IRQ_W-1:0] irq_set;
  logic [`GSWC_IRQ_W-1:0] irq_clr;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      din_q <= 8'h00;
    end else begin
      din_q <= gpio_in;
    end
  end
  assign irq_set[`GSWC_IRQ_WAKE] = wake_evt && !wake_hold;
  assign irq_set[`GSWC_IRQ_PIN_CHG] = run && (din_q != gpio_in);
  assign irq_clr = (wr_en && is_reg(paddr, `GSWC_OFF_IRQ_CLR)) ?
    pwdata[`GSWC_IRQ_W-1:0] : '0;
  // set beats clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en <= '0;
    end else if (wr_en && is_reg(paddr, `GSWC_OFF_IRQ_EN)) begin
      irq_en <= pwdata[`GSWC_IRQ_W-1:0];
    end
  end
  assign irq = |(irq_stat & irq_en);

  // ============================================================
  // read data, driven combinationally during the access phase
  logic [31:0] next_prdata;
  always_comb begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      `GSWC_OFF_OE: next_prdata[7:0] = oe;
      `GSWC_OFF_DOUT: next_prdata[7:0] = dout;
      `GSWC_OFF_DIN: next_prdata[7:0] = gpio_in;
      `GSWC_OFF_STRAP: next_prdata[7:0] = strap;
      `GSWC_OFF_IRQ_STAT: next_prdata[`GSWC_IRQ_W-1:0] = irq_stat;
      `GSWC_OFF_IRQ_EN: next_prdata[`GSWC_IRQ_W-1:0] = irq_en;
      `GSWC_OFF_WAKE_CTRL: next_prdata[0] = wake_en;
      default: next_prdata = 32'h0000_0000;
    endcase
  end
  // combinational read keeps pready fixed high with no wait state
  assign prdata = rd_en ? next_prdata : 32'h0000_0000;
endmodule : gswc_top
`default_nettype wire

//--- logic/gswc_params.svh
/*
  gswc_params.svh: offsets, field positions, reset values for the gpio/strap/wake block.
  assumes: included by the package and by the design module.
*/
`ifndef GSWC_PARAMS_SVH
`define GSWC_PARAMS_SVH
// ============================================================
// register byte offsets
`define GSWC_OFF_OE 12'h000
`define GSWC_OFF_DOUT 12'h004
`define GSWC_OFF_DIN 12'h008
`define GSWC_OFF_STRAP 12'h00c
`define GSWC_OFF_IRQ_STAT 12'h010
`define GSWC_OFF_IRQ_EN 12'h014
`define GSWC_OFF_IRQ_CLR 12'h018
`define GSWC_OFF_WAKE_CTRL 12'h01c
// ============================================================
// strap field positions on the gpio pins
`define GSWC_POS_EEW 7
`define GSWC_POS_RX_HI 6
`define GSWC_POS_RX_LO 5
`define GSWC_POS_TX_HI 4
`define GSWC_POS_TX_LO 3
`define GSWC_POS_DEQ_HI 2
`define GSWC_POS_DEQ_LO 0
// ============================================================
// reset values
`define GSWC_RST_OE 8'h00
`define GSWC_RST_DOUT 8'h00
`define GSWC_RST_RX 2'h0
`define GSWC_RST_TX 2'h0
`define GSWC_RST_DEQ 3'h4
// ============================================================
// interrupt bit positions
`define GSWC_IRQ_WAKE 0
`define GSWC_IRQ_PIN_CHG 1
`define GSWC_IRQ_W 2
`endif

//--- logic/gswc_pkg.sv
/*
  gswc_pkg.sv: types for the gpio/strap/wake block.
  assumes: gswc_params.svh on the include path.
*/
`include "gswc_params.svh"
package gswc_pkg;
  // ============================================================
  // captured strap values
  typedef struct packed {
    logic eeprom_width_strap;
    logic [1:0] rx_termination_trim;
    logic [1:0] tx_termination_trim;
    logic [2:0] driver_equalization_level;
  } gswc_strap_s;

  // ============================================================
  // general purpose pin output and enable pair
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
  } gswc_pin_drive_s;

  typedef enum logic [1:0] {
    GSWC_ST_RESET = 2'b00,
    GSWC_ST_SAMPLE = 2'b01,
    GSWC_ST_RUN = 2'b10
  } gswc_state_e;
endpackage : gswc_pkg

//--- tb/gswc_board.sv
/* gswc_board.sv: board side of the eight pins, pulls and strap drivers.
  assumes: pin signals of gswc_top, levels settle within a pclk cycle. */
`timescale 1ns/10ps
`default_nettype none
module gswc_board #(
  parameter logic [7:0] PULL = 8'h04
) (
  input wire logic [7:0] gpio_out,
  input wire logic [7:0] gpio_oe_n,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  output logic [7:0] gpio_in
);
  // ====================
  // wire level: device, else board driver, else pull
  // pin 2 pulls up, the rest down
  assign gpio_in = (~gpio_oe_n & gpio_out) | (gpio_oe_n & ext_en & ext_val)
    | (gpio_oe_n & ~ext_en & PULL);
endmodule : gswc_board
`default_nettype wire

//--- tb/gswc_checker.sv
/* gswc_checker.sv: port assertions for gswc_top.
  assumes: bound to every gswc_top. */
`timescale 1ns/10ps
`default_nettype none
module gswc_checker
  import gswc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [7:0] gpio_in,
  input wire logic [7:0] gpio_oe_n,
  input wire logic ring_ch0,
  input wire logic link_in_l2,
  input wire logic wake_out_n,
  input wire gswc_strap_s strap
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ====================
  // edges since release, saturating
  logic [2:0] up;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) up <= 3'h0;
    else up <= {up[1:0], 1'b1};
  end
  sequence s_boot; up == 3'h0 ##2 1'b1; endsequence
  sequence s_wake; !wake_out_n && link_in_l2; endsequence
  // ====================
  // straps, pins, wake
  a_strap_default: assert property (up == 3'h0 |-> strap == 8'h04)
    else $error("strap not default");
  a_strap_capture: assert property (s_boot |-> strap == $past(gpio_in))
    else $error("strap not captured");
  a_strap_held: assert property (up[2] |-> $stable(strap))
    else $error("strap moved");
  a_pins_released: assert property (up == 3'h0 |-> gpio_oe_n == 8'hff ##1 gpio_oe_n == 8'hff)
    else $error("pins driven early");
  a_oe_follow: assert property (up[1] && psel && penable && pwrite && paddr == 12'h000
    |=> gpio_oe_n == ~$past(pwdata[7:0]))
    else $error("enable mismatch");
  a_wake_set: assert property (up[1] && ring_ch0 && link_in_l2 |=> !wake_out_n)
    else $error("wake missing");
  a_wake_hold: assert property (s_wake |=> !wake_out_n)
    else $error("wake dropped");
  a_wake_drop: assert property (!link_in_l2 |=> wake_out_n)
    else $error("wake stuck");
endmodule : gswc_checker
bind gswc_top gswc_checker i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .gpio_in, .gpio_oe_n, .ring_ch0, .link_in_l2, .wake_out_n, .strap);
`default_nettype wire

//--- tb/gswc_tb_top.sv
/* gswc_tb_top.sv: apb tests of gswc_top.
  assumes: gswc_board on the pins. */
`timescale 1ns/10ps
`default_nettype none
module gswc_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ring = 0, l2 = 0;
  logic pready, pslverr, irq, wake_n, er;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [7:0] gin, gout, goe_n, strap, ev = 8'ha5, ee = 8'hff;
  int errors = 0, n_tests = 0;
  always #50 pclk = ~pclk;
  gswc_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .gpio_in(gin), .gpio_out(gout), .gpio_oe_n(goe_n), .ring_ch0(ring),
    .link_in_l2(l2), .wake_out_n(wake_n), .strap, .irq);
  gswc_board i_brd (.gpio_out(gout), .gpio_oe_n(goe_n), .ext_val(ev), .ext_en(ee),
    .gpio_in(gin));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  // ====================
  // apb transfer, idle cycle first so no signal is set twice
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      errors++;
      summarize();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  // ====================
  // tests
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(strap, 8'ha5);
    chk(goe_n, 8'hff);
    ev <= 8'h3c;
    xfer(0, 12'h00c, 0);
    chk(rd, 8'ha5);
    chk(strap, 8'ha5);
    $display("end strap");
    xfer(1, 12'h000, 32'h0f);
    xfer(1, 12'h004, 32'h5a);
    xfer(0, 12'h008, 0);
    chk(rd, 32'h3a);
    chk(goe_n, 8'hf0);
    chk(gout, 8'h5a);
    $display("end pins");
    xfer(1, 12'h014, 32'h1);
    ring <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(wake_n, 1'b1);
    l2 <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(wake_n, 1'b0);
    chk(irq, 1'b1);
    ring <= 1'b0;
    xfer(1, 12'h018, 32'h1);
    // outputs read at the access edge still show the old state, so let one edge pass
    @(posedge pclk);
    chk(irq, 1'b0);
    chk(wake_n, 1'b0);
    xfer(1, 12'h014, 0);
    // a held wake raises no new event: leave L2 first, then ring again
    l2 <= 1'b0;
    @(posedge pclk);
    l2 <= 1'b1;
    ring <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    chk(wake_n, 1'b0);
    xfer(0, 12'h010, 0);
    chk(rd[0], 1'b1);
    ring <= 1'b0;
    l2 <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(wake_n, 1'b1);
    $display("end wake");
    xfer(0, 12'h020, 0);
    chk(er, 1'b1);
    chk(rd, 0);
    ee <= 8'h00;
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(strap, 8'h04);
    xfer(0, 12'h000, 0);
    chk(rd, 0);
    $display("end defaults");
    summarize();
  end
endmodule : gswc_tb_top
`default_nettype wire
